// ---- src/sysctl_pkg.sv ----
// Shared constants for the system control register bank
package sysctl_pkg;
  // Register select codes for move-to/from-control-register operations
  localparam logic [3:0] SEL_MODE     = 4'h0;
  localparam logic [3:0] SEL_FAULT    = 4'h2;
  localparam logic [3:0] SEL_PAGE     = 4'h3;
  localparam logic [3:0] SEL_EXT      = 4'h4;
  localparam logic [3:0] SEL_PRIO     = 4'h8;
  // Mode control field positions
  localparam int PROT_EN_BIT     = 0;
  localparam int WAIT_MON_BIT    = 1;
  localparam int FPU_ABSENT_BIT  = 2;
  localparam int TASK_SW_BIT     = 3;
  localparam int COPROC_TYPE_BIT = 4;
  localparam int NATIVE_ERR_BIT  = 5;
  localparam int WRITE_PROT_BIT  = 16;
  localparam int ALIGN_MASK_BIT  = 18;
  localparam int NO_WB_BIT       = 29;
  localparam int CACHE_DIS_BIT   = 30;
  localparam int PAGING_EN_BIT   = 31;
  // Page base register reserved field and root alignment
  localparam int PB_RSV_HI        = 51;
  localparam int PB_RSV_LO        = 40;
  localparam int PB_ALIGN         = 12;
  localparam int ROOT_WT_BIT      = 3;
  localparam int ROOT_NOCACHE_BIT = 4;
  // Reset values
  localparam logic [31:0] MODE_RESET  = 32'h0000_0010;
  localparam logic [31:0] TASK_LIMIT_RESET = 32'h0000_FFFF;
  localparam logic [63:0] ZERO64      = 64'h0000_0000_0000_0000;
  // Writable mask of the mode control register
  localparam logic [31:0] MODE_WMASK  = 32'hE005_002F;
  // Privilege levels: kernel may reach control registers, user level gates alignment checks
  localparam logic [1:0]  PRIV_KERNEL = 2'h0;
  localparam logic [1:0]  PRIV_USER   = 2'h3;
endpackage

// ---- src/fpu_gate.sv ----
`timescale 1ns/10ps
// Floating-point availability gate and legacy error pin logic
module fpu_gate
  import sysctl_pkg::*;
(
  input  wire logic SYS_CLK,
  input  wire logic RESET,
  input  wire logic [31:0] mode,
  input  wire logic fp_op,
  input  wire logic fp_exempt,
  input  wire logic wait_op,
  input  wire logic fp_err,
  input  wire logic err_ignore,
  output logic      nm_fault,
  output logic      err_out,
  output logic      stall
);
  logic err_pend_q; // Pending legacy error
  // Lazy context switch fault decision
  always_comb begin
    nm_fault = 1'b0;
    if (fp_op && !fp_exempt && (mode[FPU_ABSENT_BIT] || mode[TASK_SW_BIT])) begin
      nm_fault = 1'b1;
    end else if (wait_op && mode[WAIT_MON_BIT] && mode[TASK_SW_BIT]) begin
      nm_fault = 1'b1;
    end // Else wait runs, even with the task switched flag set
  end
  // Legacy error latch; native mode or ignore input suppresses it
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      err_pend_q <= 1'b0;
    end else if (fp_err && !mode[NATIVE_ERR_BIT] && !err_ignore) begin
      err_pend_q <= 1'b1;
    end else if (mode[NATIVE_ERR_BIT] || err_ignore) begin
      err_pend_q <= 1'b0;
    end
  end
  assign err_out = err_pend_q;
  // Halt before the next waiting float or wait instruction
  assign stall   = err_pend_q && (wait_op || fp_op);
endmodule

// ---- src/system_control_registers.sv ----
`timescale 1ns/10ps
// System control register bank with task selector register
module system_control_registers
  import sysctl_pkg::*;
#(
  parameter int ATTR_W = 12
) (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  // Processor mode
  input  wire logic        LONG64,
  input  wire logic        PROTECTED,
  input  wire logic        V86,
  input  wire logic [1:0]  CURRENT_PRIVILEGE_LEVEL,
  // Control register move operations
  input  wire logic        CR_WR,
  input  wire logic        CR_RD,
  input  wire logic [3:0]  CR_SEL,
  input  wire logic [63:0] CR_WDATA,
  output logic [63:0]      CR_RDATA,
  output logic             CR_RVALID,
  output logic             PROT_FAULT,
  // Task register loads and task switches
  input  wire logic        LOAD_TASK_SEL,
  input  wire logic        TASK_SWITCH,
  input  wire logic [15:0] TASK_SEL_IN,
  input  wire logic [63:0] TASK_BASE_IN,
  input  wire logic [31:0] TASK_LIMIT_IN,
  input  wire logic [ATTR_W-1:0] TASK_ATTR_IN,
  output logic [15:0]      TASK_SEL,
  output logic [63:0]      TASK_BASE,
  output logic [31:0]      TASK_LIMIT,
  output logic [ATTR_W-1:0] TASK_ATTR,
  // Page fault capture and clear of task switched flag
  input  wire logic        PAGE_FAULT,
  input  wire logic [63:0] PAGE_FAULT_ADDR,
  input  wire logic        CLEAR_TS,
  // Floating-point instruction stream
  input  wire logic        FP_OP,
  input  wire logic        FP_EXEMPT,
  input  wire logic        WAIT_OP,
  input  wire logic        FP_ERR,
  input  wire logic        FPU_ERROR_IGNORE_IN,
  output logic             DEV_UNAVAIL_FAULT,
  output logic             FPU_ERROR_OUT,
  output logic             FP_STALL,
  // Decoded controls to the core
  input  wire logic        USER_ALIGN_CHECK,
  output logic             PAGING_ON,
  output logic             CACHE_WB_ALL,
  output logic             ALIGN_CHECK_ON,
  output logic             WRITE_PROTECT,
  output logic [63:0]      PAGE_ROOT,
  output logic [3:0]       PRIORITY_THRESHOLD
);
  // Elaboration checks: attribute field must fit a descriptor word
  if (ATTR_W < 1 || ATTR_W > 16) begin : g_attr_check
    $error("ATTR_W out of range");
  end
  // Reserved page field must sit above the alignment bits
  if (PB_RSV_LO <= PB_ALIGN || PB_RSV_HI > 63) begin : g_page_check
    $error("page base field positions out of range");
  end
  // The fixed type bit must stay outside the write mask
  if (MODE_WMASK[COPROC_TYPE_BIT] != 1'b0) begin : g_mask_check
    $error("write mask covers the fixed type bit");
  end

  logic [31:0] mode_q;       // Mode control register
  logic [63:0] fault_q;      // Fault address register
  logic [63:0] page_q;       // Page base register
  logic [31:0] ext_q;        // Extension enable register, opaque here
  logic [3:0]  prio_q;       // Priority threshold
  logic        priv_ok;      // Access permitted
  logic        sel_ok;       // Selector names a real register
  logic        gp_wr;        // Write would fault
  logic        wr_go;        // Write commits
  logic        rd_go;        // Read answered
  logic        wr_mode;      // Commit to mode control
  logic        wr_fault;     // Commit to fault address
  logic        wr_page;      // Commit to page base
  logic        wr_ext;       // Commit to extension enable
  logic        wr_prio;      // Commit to priority threshold
  logic        nm_c;         // Unavailable fault, combinational
  logic        err_c;        // Legacy error level
  logic        stall_c;      // Halt request
  logic [63:0] rd_c;         // Read mux
  logic [63:0] wdata_c;      // Width-trimmed write data

  // Only privilege zero may touch control registers in protected mode
  assign priv_ok = !PROTECTED || (CURRENT_PRIVILEGE_LEVEL == PRIV_KERNEL);
  // Priority register exists only in long mode
  assign sel_ok  = (CR_SEL == SEL_MODE) || (CR_SEL == SEL_FAULT) ||
                   (CR_SEL == SEL_PAGE) || (CR_SEL == SEL_EXT) ||
                   ((CR_SEL == SEL_PRIO) && LONG64);
  // Outside long mode only the low word counts, prefixes or not
  assign wdata_c = LONG64 ? CR_WDATA : {32'h0000_0000, CR_WDATA[31:0]};

  // Fault decode for a write
  always_comb begin
    // Wrong privilege or a select with no register behind it
    gp_wr = !priv_ok || !sel_ok;
    // Upper half is reserved in mode and extension registers
    if ((CR_SEL == SEL_MODE || CR_SEL == SEL_EXT) && (wdata_c[63:32] != 32'h0000_0000)) begin
      gp_wr = 1'b1;
    end
    // Paging cannot be turned on without protection
    if (CR_SEL == SEL_MODE && wdata_c[PAGING_EN_BIT] && !wdata_c[PROT_EN_BIT]) begin
      gp_wr = 1'b1;
    end
  end
  assign wr_go = CR_WR && !gp_wr;
  // One strobe per register keeps each storage process a plain enable
  assign wr_mode  = wr_go && (CR_SEL == SEL_MODE);
  assign wr_fault = wr_go && (CR_SEL == SEL_FAULT);
  assign wr_page  = wr_go && (CR_SEL == SEL_PAGE);
  assign wr_ext   = wr_go && (CR_SEL == SEL_EXT);
  assign wr_prio  = wr_go && (CR_SEL == SEL_PRIO);
  // A read is answered only when it would not fault
  assign rd_go    = CR_RD && priv_ok && sel_ok;

  // Protection fault pulse for a bad read or write
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      PROT_FAULT <= 1'b0;
    end else begin
      PROT_FAULT <= (CR_WR && gp_wr) || (CR_RD && (!priv_ok || !sel_ok));
    end
  end

  // Mode control: writable bits kept, type bit fixed, task switch sets flag
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      mode_q <= MODE_RESET;
    end else begin
      if (wr_mode) begin
        // Fixed type bit forced back to one on every write
        mode_q <= (wdata_c[31:0] & MODE_WMASK) | MODE_RESET;
      end else if (CLEAR_TS) begin
        mode_q[TASK_SW_BIT] <= 1'b0;
      end
      // Last assignment wins: a task switch outranks clear and write
      if (TASK_SWITCH) begin
        mode_q[TASK_SW_BIT] <= 1'b1;
      end
    end
  end

  // Fault address: page fault capture outranks software write
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      fault_q <= ZERO64;
    end else if (PAGE_FAULT) begin
      fault_q <= PAGE_FAULT_ADDR;
    end else if (wr_fault) begin
      fault_q <= wdata_c;
    end
  end

  // Page base: no width check; reserved bits held zero
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      page_q <= ZERO64;
    end else if (wr_page) begin
      page_q <= wdata_c;
      page_q[PB_RSV_HI:PB_RSV_LO] <= 12'h000;
    end
  end

  // Extension enable storage; its fields are not decoded in this block
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ext_q <= 32'h0000_0000;
    end else if (wr_ext) begin
      ext_q <= wdata_c[31:0];
    end
  end

  // Priority threshold; only the low four bits are kept
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      prio_q <= 4'h0;
    end else if (wr_prio) begin
      prio_q <= wdata_c[3:0];
    end
  end

  // Task register: reset, selector load, or task switch reload
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      TASK_SEL   <= 16'h0000;
      TASK_BASE  <= ZERO64;
      TASK_LIMIT <= TASK_LIMIT_RESET;
      TASK_ATTR  <= '0;
    end else if (LOAD_TASK_SEL || TASK_SWITCH) begin
      // Old contents overwritten without any save
      TASK_SEL   <= TASK_SEL_IN;
      TASK_BASE  <= LONG64 ? TASK_BASE_IN : {32'h0000_0000, TASK_BASE_IN[31:0]};
      TASK_LIMIT <= TASK_LIMIT_IN;
      TASK_ATTR  <= TASK_ATTR_IN;
    end
  end

  // Read mux; upper half zero outside long mode
  always_comb begin
    // Unused selects read as zero
    rd_c = ZERO64;
    if (CR_SEL == SEL_MODE) begin
      rd_c = {32'h0000_0000, mode_q};
    end else if (CR_SEL == SEL_FAULT) begin
      rd_c = fault_q;
    end else if (CR_SEL == SEL_PAGE) begin
      rd_c = page_q;
    end else if (CR_SEL == SEL_EXT) begin
      rd_c = {32'h0000_0000, ext_q};
    end else if (CR_SEL == SEL_PRIO) begin
      rd_c = {60'h0, prio_q};
    end
    if (!LONG64) begin
      rd_c[63:32] = 32'h0000_0000;
    end
  end

  // Read answer registered one cycle after the request
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      CR_RDATA  <= ZERO64;
      CR_RVALID <= 1'b0;
    end else begin
      CR_RVALID <= rd_go;
      // Refused reads return zero so no register value leaks
      CR_RDATA  <= rd_go ? rd_c : ZERO64;
    end
  end

  // Floating-point gate
  fpu_gate u_fpu (
    .SYS_CLK    (SYS_CLK),
    .RESET      (RESET),
    .mode       (mode_q),
    .fp_op      (FP_OP),
    .fp_exempt  (FP_EXEMPT),
    .wait_op    (WAIT_OP),
    .fp_err     (FP_ERR),
    .err_ignore (FPU_ERROR_IGNORE_IN),
    .nm_fault   (nm_c),
    .err_out    (err_c),
    .stall      (stall_c)
  );

  // Registered floating-point answers from the gate
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      DEV_UNAVAIL_FAULT <= 1'b0;
      FPU_ERROR_OUT     <= 1'b0;
      FP_STALL          <= 1'b0;
    end else begin
      DEV_UNAVAIL_FAULT <= nm_c;
      FPU_ERROR_OUT     <= err_c;
      FP_STALL          <= stall_c;
    end
  end

  // Registered decoded controls; filtering by threshold stays in all modes
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      PAGING_ON          <= 1'b0;
      CACHE_WB_ALL       <= 1'b0;
      ALIGN_CHECK_ON     <= 1'b0;
      WRITE_PROTECT      <= 1'b0;
      PAGE_ROOT          <= ZERO64;
      PRIORITY_THRESHOLD <= 4'h0;
    end else begin
      // Paging only counts with protection on
      PAGING_ON          <= mode_q[PAGING_EN_BIT] && mode_q[PROT_EN_BIT];
      CACHE_WB_ALL       <= !mode_q[CACHE_DIS_BIT] && !mode_q[NO_WB_BIT];
      // All four conditions, in protected or virtual-8086 mode
      ALIGN_CHECK_ON     <= mode_q[ALIGN_MASK_BIT] && USER_ALIGN_CHECK &&
                            (CURRENT_PRIVILEGE_LEVEL == PRIV_USER) &&
                            (PROTECTED || V86);
      WRITE_PROTECT      <= mode_q[WRITE_PROT_BIT];
      // Low twelve root bits always zero, so the root is page aligned
      PAGE_ROOT          <= {page_q[63:PB_ALIGN], 12'h000};
      PRIORITY_THRESHOLD <= prio_q;
    end
  end
endmodule

// ---- tb/sysctl_asserts.sv ----
// Port-level checks for the system control register bank
`timescale 1ns/10ps
module sysctl_asserts
  import sysctl_pkg::*;
(
  // Clock, reset and processor mode
  input wire logic        SYS_CLK, RESET, LONG64, PROTECTED,
  input wire logic [1:0]  CURRENT_PRIVILEGE_LEVEL,
  // Move operations and their answers
  input wire logic        CR_WR, CR_RD, CR_RVALID, PROT_FAULT,
  input wire logic [3:0]  CR_SEL,
  input wire logic [63:0] CR_WDATA, CR_RDATA, PAGE_ROOT,
  // Task register and page fault capture
  input wire logic        LOAD_TASK_SEL, TASK_SWITCH, PAGE_FAULT,
  input wire logic [15:0] TASK_SEL_IN, TASK_SEL,
  input wire logic [31:0] TASK_LIMIT_IN, TASK_LIMIT,
  input wire logic [63:0] TASK_BASE, PAGE_FAULT_ADDR,
  // Floating-point gate
  input wire logic        FP_OP, FP_EXEMPT, DEV_UNAVAIL_FAULT
);
  // One clock domain, so one default clocking and disable
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // Only kernel code may reach the registers in protected mode
  wire kern = (CURRENT_PRIVILEGE_LEVEL == PRIV_KERNEL);
  reset_task_a: assert property (
    $fell(RESET) |-> TASK_LIMIT == TASK_LIMIT_RESET && TASK_BASE == ZERO64)
    else $error("task register reset value wrong");
  task_load_a: assert property (
    LOAD_TASK_SEL || TASK_SWITCH |=> TASK_SEL == $past(TASK_SEL_IN)
      && TASK_LIMIT == $past(TASK_LIMIT_IN)) else $error("task register load wrong");
  mode_read_a: assert property (
    CR_RD && kern && CR_SEL == SEL_MODE |=> CR_RVALID && CR_RDATA[COPROC_TYPE_BIT])
    else $error("mode read answer wrong");
  priv_refuse_a: assert property (
    (CR_WR || CR_RD) && PROTECTED && !kern |=> PROT_FAULT && !CR_RVALID)
    else $error("user access not refused");
  upper_refuse_a: assert property (
    CR_WR && kern && LONG64 && (CR_SEL == SEL_MODE || CR_SEL == SEL_EXT)
      && CR_WDATA[63:32] != 0 |=> PROT_FAULT) else $error("upper half write not refused");
  paging_refuse_a: assert property (
    CR_WR && kern && CR_SEL == SEL_MODE && CR_WDATA[PAGING_EN_BIT] && !CR_WDATA[PROT_EN_BIT]
      |=> PROT_FAULT) else $error("paging without protection not refused");
  prio_refuse_a: assert property (
    CR_WR && CR_SEL == SEL_PRIO && !LONG64 |=> PROT_FAULT)
    else $error("priority write outside long mode not refused");
  fault_capture_a: assert property (
    PAGE_FAULT ##1 (CR_RD && kern && LONG64 && CR_SEL == SEL_FAULT && !PAGE_FAULT)
      |=> CR_RDATA == $past(PAGE_FAULT_ADDR, 2)) else $error("fault address not captured");
  switch_fault_a: assert property (
    TASK_SWITCH ##1 (FP_OP && !FP_EXEMPT) |=> DEV_UNAVAIL_FAULT)
    else $error("float op after task switch ran");
  root_align_a: assert property (
    PAGE_ROOT[11:0] == 12'h000 && PAGE_ROOT[PB_RSV_HI:PB_RSV_LO] == 12'h000)
    else $error("page root alignment wrong");
endmodule

bind system_control_registers sysctl_asserts i_chk (.*);

// ---- tb/system_control_registers_bench.sv ----
// Directed bench for the system control register bank
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module system_control_registers_bench
  import sysctl_pkg::*;
;
  // Design ports, named as on the block
  logic SYS_CLK, RESET, LONG64, PROTECTED, V86, CR_WR, CR_RD, CR_RVALID, PROT_FAULT;
  logic LOAD_TASK_SEL, TASK_SWITCH, PAGE_FAULT, CLEAR_TS, FP_OP, FP_EXEMPT, WAIT_OP;
  logic FP_ERR, FPU_ERROR_IGNORE_IN, DEV_UNAVAIL_FAULT, FPU_ERROR_OUT, FP_STALL;
  logic USER_ALIGN_CHECK, PAGING_ON, CACHE_WB_ALL, ALIGN_CHECK_ON, WRITE_PROTECT;
  logic [1:0]  CURRENT_PRIVILEGE_LEVEL;
  logic [3:0]  CR_SEL, PRIORITY_THRESHOLD;
  logic [11:0] TASK_ATTR_IN, TASK_ATTR;
  logic [15:0] TASK_SEL_IN, TASK_SEL;
  logic [31:0] TASK_LIMIT_IN, TASK_LIMIT;
  logic [63:0] CR_WDATA, CR_RDATA, TASK_BASE_IN, TASK_BASE, PAGE_FAULT_ADDR, PAGE_ROOT;
  int          err_count, samples_checked;

  system_control_registers i_dut (.*);

  // 100 MHz clock
  initial begin
    SYS_CLK = 0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  // Inputs move 1 ns after the edge, clear of sampling
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask

  // One move operation, then an idle cycle so calls may follow back to back
  task automatic acc(input logic w, input logic [3:0] s, input logic [63:0] d, input logic f);
    CR_WR = w;
    CR_RD = !w;
    CR_SEL = s;
    CR_WDATA = d;
    tick(1);
    CR_WR = 0;
    CR_RD = 0;
    `CHK(PROT_FAULT, f)
    if (!w) `CHK(CR_RVALID, !f)
    if (!w && !f) `CHK(CR_RDATA, d)
    tick(1);
  endtask

  // Selector load or task switch with a descriptor made from the selector
  task automatic tsk(input logic sw, input logic [15:0] s);
    TASK_SEL_IN = s;
    TASK_BASE_IN = {s, 48'h0000_1234_5000};
    TASK_LIMIT_IN = {16'h0000, s};
    TASK_ATTR_IN = s[11:0];
    LOAD_TASK_SEL = !sw;
    TASK_SWITCH = sw;
    tick(1);
    LOAD_TASK_SEL = 0;
    TASK_SWITCH = 0;
    `CHK(TASK_SEL, s)
    `CHK(TASK_BASE, {s, 48'h0000_1234_5000})
    `CHK(TASK_LIMIT, {16'h0000, s})
    `CHK(TASK_ATTR, s[11:0])
  endtask

  // One floating-point cycle and the expected fault answer
  task automatic fp(input logic o, input logic e, input logic w, input logic f);
    FP_OP = o;
    FP_EXEMPT = e;
    WAIT_OP = w;
    tick(1);
    {FP_OP, FP_EXEMPT, WAIT_OP} = 3'b000;
    `CHK(DEV_UNAVAIL_FAULT, f)
    tick(1);
  endtask

  // Counts, verdict and end of run
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {V86, CURRENT_PRIVILEGE_LEVEL, CR_WR, CR_RD, CR_SEL, LOAD_TASK_SEL, TASK_SWITCH} = '0;
    {CLEAR_TS, FP_OP, FP_EXEMPT, WAIT_OP, FP_ERR, FPU_ERROR_IGNORE_IN} = '0;
    {CR_WDATA, TASK_SEL_IN, TASK_BASE_IN, TASK_LIMIT_IN, TASK_ATTR_IN} = '0;
    {PAGE_FAULT, PAGE_FAULT_ADDR, USER_ALIGN_CHECK} = '0;
    err_count = 0;
    samples_checked = 0;
    RESET = 1;
    PROTECTED = 1;
    LONG64 = 1;
    tick(3);
    RESET = 0;
    `CHK(TASK_LIMIT, 32'h0000_FFFF)
    `CHK(TASK_BASE, 64'h0000_0000_0000_0000)
    acc(0, SEL_MODE, 64'h0000_0000_0000_0010, 0);
    acc(1, SEL_MODE, 64'h0000_0000_FFFF_FFFF, 0);
    acc(0, SEL_MODE, 64'h0000_0000_E005_003F, 0);
    USER_ALIGN_CHECK = 1;
    `CHK({PAGING_ON, WRITE_PROTECT, CACHE_WB_ALL}, 3'b110)
    tick(2);
    `CHK(ALIGN_CHECK_ON, 1'b0)
    CURRENT_PRIVILEGE_LEVEL = 2'h3;
    tick(2);
    `CHK(ALIGN_CHECK_ON, 1'b1)
    PROTECTED = 0;
    V86 = 1;
    tick(2);
    `CHK(ALIGN_CHECK_ON, 1'b1)
    V86 = 0;
    tick(2);
    `CHK(ALIGN_CHECK_ON, 1'b0)
    acc(0, SEL_MODE, 64'h0000_0000_E005_003F, 0);
    PROTECTED = 1;
    acc(1, SEL_MODE, 64'h0000_0000_0000_0001, 1);
    acc(0, SEL_MODE, 64'h0000_0000_0000_0000, 1);
    CURRENT_PRIVILEGE_LEVEL = 2'h0;
    USER_ALIGN_CHECK = 0;
    acc(1, SEL_MODE, 64'h0000_0001_0000_0001, 1);
    acc(1, SEL_EXT, 64'h8000_0000_0000_0000, 1);
    acc(1, SEL_MODE, 64'h0000_0000_8000_0000, 1);
    acc(0, SEL_MODE, 64'h0000_0000_E005_003F, 0);
    acc(1, SEL_MODE, 64'h0000_0000_0000_0001, 0);
    `CHK({PAGING_ON, WRITE_PROTECT, CACHE_WB_ALL}, 3'b001)
    acc(1, SEL_FAULT, 64'hFFFF_FFFF_FFFF_FFFF, 0);
    acc(0, SEL_FAULT, 64'hFFFF_FFFF_FFFF_FFFF, 0);
    acc(1, SEL_PAGE, 64'hFFFF_FFFF_FFFF_FFFF, 0);
    acc(0, SEL_PAGE, 64'hFFF0_00FF_FFFF_FFFF, 0);
    `CHK(PAGE_ROOT, 64'hFFF0_00FF_FFFF_F000)
    PAGE_FAULT_ADDR = 64'h0123_4567_89AB_CDEF;
    PAGE_FAULT = 1;
    tick(1);
    PAGE_FAULT = 0;
    acc(0, SEL_FAULT, 64'h0123_4567_89AB_CDEF, 0);
    acc(1, SEL_PRIO, 64'h0000_0000_0000_0005, 0);
    acc(0, SEL_PRIO, 64'h0000_0000_0000_0005, 0);
    LONG64 = 0;
    acc(1, SEL_PRIO, 64'h0000_0000_0000_0003, 1);
    `CHK(PRIORITY_THRESHOLD, 4'h5)
    acc(0, SEL_FAULT, 64'h0000_0000_89AB_CDEF, 0);
    LONG64 = 1;
    tsk(0, 16'h0028);
    tick(1);
    tsk(1, 16'h0030);
    fp(1, 0, 0, 1);
    acc(0, SEL_MODE, 64'h0000_0000_0000_0019, 0);
    fp(1, 1, 0, 0);
    fp(0, 0, 1, 0);
    acc(1, SEL_MODE, 64'h0000_0000_0000_000B, 0);
    fp(0, 0, 1, 1);
    acc(1, SEL_MODE, 64'h0000_0000_0000_0005, 0);
    fp(1, 0, 0, 1);
    fp(0, 0, 1, 0);
    acc(1, SEL_MODE, 64'h0000_0000_0000_0009, 0);
    CLEAR_TS = 1;
    tick(1);
    CLEAR_TS = 0;
    fp(1, 0, 0, 0);
    FP_ERR = 1;
    tick(1);
    FP_ERR = 0;
    FP_OP = 1;
    tick(2);
    FP_OP = 0;
    `CHK({FPU_ERROR_OUT, FP_STALL}, 2'b11)
    FPU_ERROR_IGNORE_IN = 1;
    FP_ERR = 1;
    tick(2);
    FP_ERR = 0;
    `CHK(FPU_ERROR_OUT, 1'b0)
    FPU_ERROR_IGNORE_IN = 0;
    acc(1, SEL_MODE, 64'h0000_0000_0000_0021, 0);
    FP_ERR = 1;
    tick(2);
    FP_ERR = 0;
    `CHK(FPU_ERROR_OUT, 1'b0)
    close_out();
  end

  // Hang guard, far beyond the directed run
  initial begin
    #100000;
    err_count++;
    close_out();
  end
endmodule
